//--- pmw_pkg.sv
package pmw_pkg;

	// ****************************************
	// Clock rates and timing
	// ****************************************
	localparam int CLK_KHZ          = 200000;
	localparam int IRC_KHZ          = 12000;
	localparam int IRC_STARTUP_US   = 60;
	localparam int FLASH_STARTUP_US = 100;
	localparam int FAST_WAKE_CYC    = 4;
	localparam int MAIN_WAKE_CYC    = 4096;
	localparam int IRC_STARTUP_CYC  = (IRC_STARTUP_US * IRC_KHZ + 999) / 1000;
	localparam int FLASH_WAKE_CYC   = (FLASH_STARTUP_US * IRC_KHZ + 999) / 1000;
	localparam int RST_HOLD_CYC     = 64;
	localparam int TMR_W            = 13;
	localparam int ACC_W            = 18;

	// ****************************************
	// Register map
	// ****************************************
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_PCLK   = 8'h04;
	localparam logic [7:0] OFS_STATUS = 8'h08;
	localparam logic [7:0] OFS_DIV    = 8'h0C;
	localparam logic [7:0] OFS_CLKCFG = 8'h10;

	localparam int CTRL_MODE_LSB  = 0;
	localparam int CTRL_RTCKEEP   = 2;
	localparam int STAT_EXIT_LSB  = 0;
	localparam int STAT_FLASH_OK  = 4;
	localparam int STAT_EXEC      = 5;
	localparam int STAT_STATE_LSB = 8;

	localparam logic [31:0] PCLK_RST   = 32'hFFFF_FFFF;
	localparam logic [7:0]  DIV_RST    = 8'h00;
	localparam logic [1:0]  CLKSEL_RST = 2'h0;

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [1:0] {
		MODE_SLEEP  = 2'b00,
		MODE_DSLEEP = 2'b01,
		MODE_PDOWN  = 2'b10,
		MODE_DPD    = 2'b11
	} pmw_mode_e;

	typedef enum logic [3:0] {
		ST_RST_HOLD = 4'b0000,
		ST_RUN      = 4'b0001,
		ST_SLEEP    = 4'b0010,
		ST_DSLEEP   = 4'b0011,
		ST_PDOWN    = 4'b0100,
		ST_DPD      = 4'b0101,
		ST_OSC_UP   = 4'b0110,
		ST_RESUME   = 4'b0111
	} pmw_state_e;

	typedef struct packed {
		logic       pll0_en;
		logic       pll1_en;
		logic       pll_conn;
		logic       main_osc_en;
		logic       use_main;
		logic [1:0] clk_sel;
	} pmw_clkcfg_s;

	localparam pmw_clkcfg_s CLKCFG_RST = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, CLKSEL_RST};

endpackage : pmw_pkg

//--- pmw_timer.sv
`timescale 1ns/10ps
module pmw_timer
	import pmw_pkg::*;
#(
	parameter int W = TMR_W
) (
	input  wire logic         clk_in,
	input  wire logic         rstn_in,
	input  wire logic         tick_in,
	input  wire logic         load_in,
	input  wire logic [W-1:0] value_in,
	output logic              done_out
);

	logic [W-1:0] cnt_ff;
	logic         done_ff;
	wire          last = (cnt_ff == W'(1));

	// Load wins over a pending tick so a restart is never shortened
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			cnt_ff  <= '0;
			done_ff <= 1'b0;
		end else if (load_in) begin
			cnt_ff  <= value_in;
			done_ff <= 1'b0;
		end else if (tick_in && !done_ff && cnt_ff != '0) begin
			cnt_ff  <= cnt_ff - W'(1);
			done_ff <= last;
		end
	end

	assign done_out = done_ff;

endmodule : pmw_timer

//--- pmw_sequencer.sv
// The placing of the registers and the APB register port were decided locally.
`timescale 1ns/10ps
// Functional notes
// - Clock source is internal_rc_osc after power-up and Power-down wake until software picks
// - Wake-up timer holds execution after reset and Power-down exit
// - Sleep stops the core clock; resume just re-enables it
// - Sleep suspends execution until reset or interrupt; peripherals keep running
// - Sleep keeps DMA alive; flash and main SRAM disabled
// - Any enabled active interrupt ends Sleep
// - Deep-sleep stops oscillator and clocks, retains state, holds pins static
// - Deep-sleep gates internal_rc_osc output but keeps it powered; RTC osc runs
// - Deep-sleep entry turns off and disconnects PLL, zeroes dividers
// - Flash stays powered in Deep-sleep
// - Deep-sleep wakes from any enabled listed interrupt source
// - Deep-sleep wake resumes after 4 cycles (RC) or 4096 (main osc)
// - Power-down adds internal_rc_osc and flash power off, flash powered down
// - Power-down stops oscillators, both PLLs, resets selectors and dividers
// - Watchdog and RTC keep running in Power-down
// - Power-down wake: 60 us RC start-up, then four RC cycles
// - Flash wake counter covers 100 us in RC cycles; flash blocked until done
// - Deep power-down unpowers all but RTC; wake by reset pin or alarm
// - wake_interrupt_logic latches interrupt mask at entry, wakes on masked interrupt
// - Per-peripheral clock enables
// - Deep power-down option to keep or drop RTC oscillator power
// - Internal reset held until osc runs, fixed count passes, flash init done
module pmw_sequencer
	import pmw_pkg::*;
#(
	parameter int NIRQ = 16,
	parameter int NPER = 32,
	parameter int DIVW = 8
) (
	input  wire logic              CLOCK_IN,
	input  wire logic              RSTN_IN,
	input  wire logic              PSEL_IN,
	input  wire logic              PENABLE_IN,
	input  wire logic              PWRITE_IN,
	input  wire logic [7:0]        PADDR_IN,
	input  wire logic [31:0]       PWDATA_IN,
	output logic [31:0]            PRDATA_OUT,
	output logic                   PREADY_OUT,
	output logic                   PSLVERR_OUT,
	input  wire logic              SLEEP_REQ_IN,
	input  wire logic [NIRQ-1:0]   IRQ_IN,
	input  wire logic [NIRQ-1:0]   WAKE_MASK_IN,
	input  wire logic              RTC_ALARM_IN,
	input  wire logic              OSC_OK_IN,
	input  wire logic              FLASH_INIT_DONE_IN,
	input  wire logic              WDT_RUN_IN,
	output logic                   CORE_CLK_EN_OUT,
	output logic                   EXEC_EN_OUT,
	output logic                   FLASH_ACCESS_OUT,
	output logic                   FLASH_PWR_OUT,
	output logic                   SRAM_EN_OUT,
	output logic                   DMA_EN_OUT,
	output logic                   PERIPH_CLK_ON_OUT,
	output logic                   IRC_PWR_OUT,
	output logic                   IRC_OUT_EN_OUT,
	output logic                   PIN_HOLD_OUT,
	output logic                   CORE_PWR_OUT,
	output logic                   RTC_OSC_PWR_OUT,
	output logic                   WDT_CLK_EN_OUT,
	output pmw_clkcfg_s            CLKCFG_OUT,
	output logic [DIVW-1:0]        CLK_DIV_OUT,
	output logic [NPER-1:0]        PCLK_EN_OUT
);

	// ****************************************
	// Input synchronisers
	// ****************************************
	localparam int NSYNC = NIRQ + 3;
	logic [NSYNC-1:0] sync1_ff, sync2_ff;

	always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			sync1_ff <= '0;
			sync2_ff <= '0;
		end else begin
			sync1_ff <= {IRQ_IN, RTC_ALARM_IN, OSC_OK_IN, FLASH_INIT_DONE_IN};
			sync2_ff <= sync1_ff;
		end
	end

	wire [NIRQ-1:0] irq_s      = sync2_ff[NSYNC-1:3];
	wire            alarm_s    = sync2_ff[2];
	wire            osc_ok_s   = sync2_ff[1];
	wire            flinit_s   = sync2_ff[0];

	// ****************************************
	// RC oscillator rate enable
	// ****************************************
	// Fractional divider: average rate exact, jitter one fast clock
	localparam logic [ACC_W-1:0] ACC_STEP = ACC_W'(IRC_KHZ);
	localparam logic [ACC_W-1:0] ACC_MOD  = ACC_W'(CLK_KHZ);
	logic [ACC_W-1:0] acc_ff;
	logic             tick_ff;
	wire  [ACC_W-1:0] acc_sum = acc_ff + ACC_STEP;
	wire              acc_wrap = (acc_sum >= ACC_MOD);

	always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			acc_ff  <= '0;
			tick_ff <= 1'b0;
		end else begin
			acc_ff  <= acc_wrap ? acc_sum - ACC_MOD : acc_sum;
			tick_ff <= acc_wrap;
		end
	end

	// ****************************************
	// Registers
	// ****************************************
	pmw_state_e       state_ff, nxt_state;
	pmw_mode_e        mode_ff;
	logic             rtc_keep_ff;
	logic [NPER-1:0]  pclk_ff;
	logic [DIVW-1:0]  div_ff;
	pmw_clkcfg_s      clkcfg_ff;
	logic [3:0]       exit_ff;
	logic [NIRQ-1:0]  wmask_ff;
	logic             was_main_ff;
	logic             from_pd_ff;
	logic             flash_ok_ff;
	logic [31:0]      rdata_ff;
	logic             ready_ff;
	logic             slverr_ff;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		return a == ofs;
	endfunction : hit

	wire setup   = PSEL_IN && !PENABLE_IN;
	wire wr_stb  = PSEL_IN && PENABLE_IN && ready_ff && PWRITE_IN;
	wire mapped  = hit(PADDR_IN, OFS_CTRL) || hit(PADDR_IN, OFS_PCLK) ||
	               hit(PADDR_IN, OFS_STATUS) || hit(PADDR_IN, OFS_DIV) ||
	               hit(PADDR_IN, OFS_CLKCFG);
	wire wr_ctrl = wr_stb && hit(PADDR_IN, OFS_CTRL);
	wire wr_pclk = wr_stb && hit(PADDR_IN, OFS_PCLK);
	wire wr_stat = wr_stb && hit(PADDR_IN, OFS_STATUS);
	wire wr_div  = wr_stb && hit(PADDR_IN, OFS_DIV);
	wire wr_cfg  = wr_stb && hit(PADDR_IN, OFS_CLKCFG);

	wire exec_on = (state_ff == ST_RUN);

	wire [31:0] rd_mux =
		hit(PADDR_IN, OFS_CTRL)   ? {29'h0, rtc_keep_ff, mode_ff} :
		hit(PADDR_IN, OFS_PCLK)   ? 32'(pclk_ff) :
		hit(PADDR_IN, OFS_STATUS) ? {20'h0, state_ff, 2'h0, exec_on, flash_ok_ff, exit_ff} :
		hit(PADDR_IN, OFS_DIV)    ? 32'(div_ff) :
		hit(PADDR_IN, OFS_CLKCFG) ? {25'h0, clkcfg_ff} : 32'h0000_0000;

	// Answer one cycle after setup; unmapped reads zero with error
	always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			ready_ff  <= 1'b0;
			slverr_ff <= 1'b0;
			rdata_ff  <= '0;
		end else begin
			ready_ff  <= setup;
			slverr_ff <= setup && !mapped;
			rdata_ff  <= (setup && !PWRITE_IN) ? rd_mux : '0;
		end
	end

	// ****************************************
	// Wake decode
	// ****************************************
	wire sleep_wake = |(irq_s & WAKE_MASK_IN);
	wire deep_wake  = |(irq_s & wmask_ff);
	wire enter_lp   = exec_on && SLEEP_REQ_IN;
	wire entering_deep = enter_lp && (mode_ff != MODE_SLEEP);
	wire entering_pd   = enter_lp && (mode_ff == MODE_PDOWN || mode_ff == MODE_DPD);
	wire leave_deep = (state_ff == ST_DSLEEP || state_ff == ST_PDOWN) && deep_wake;

	// Per-mode exit event, one bit per mode
	wire [3:0] exit_evt = {state_ff == ST_DPD && alarm_s,
	                       state_ff == ST_PDOWN && deep_wake,
	                       state_ff == ST_DSLEEP && deep_wake,
	                       state_ff == ST_SLEEP && sleep_wake};

	// ****************************************
	// Timers
	// ****************************************
	logic            wt_load, ft_load;
	logic [TMR_W-1:0] wt_val;
	logic            wt_done, ft_done;

	localparam logic [TMR_W-1:0] T_FAST  = TMR_W'(FAST_WAKE_CYC);
	localparam logic [TMR_W-1:0] T_MAIN  = TMR_W'(MAIN_WAKE_CYC);
	localparam logic [TMR_W-1:0] T_IRCUP = TMR_W'(IRC_STARTUP_CYC);
	localparam logic [TMR_W-1:0] T_FLASH = TMR_W'(FLASH_WAKE_CYC);
	localparam logic [TMR_W-1:0] T_RST   = TMR_W'(RST_HOLD_CYC);

	pmw_timer #(.W(TMR_W)) u_wake_tmr (
		.clk_in   (CLOCK_IN),
		.rstn_in  (RSTN_IN),
		.tick_in  (tick_ff),
		.load_in  (wt_load),
		.value_in (wt_val),
		.done_out (wt_done)
	);

	pmw_timer #(.W(TMR_W)) u_flash_tmr (
		.clk_in   (CLOCK_IN),
		.rstn_in  (RSTN_IN),
		.tick_in  (tick_ff),
		.load_in  (ft_load),
		.value_in (T_FLASH),
		.done_out (ft_done)
	);

	// ****************************************
	// Sequencer
	// ****************************************
	logic reset_arm_ff;

	always_comb begin
		nxt_state = state_ff;
		wt_load   = 1'b0;
		wt_val    = T_RST;
		ft_load   = 1'b0;
		unique case (state_ff)
			ST_RST_HOLD: begin
				wt_load = reset_arm_ff;
				if (!reset_arm_ff && wt_done && osc_ok_s && flinit_s)
					nxt_state = ST_RUN;
			end
			ST_RUN: begin
				if (enter_lp) begin
					unique case (mode_ff)
						MODE_SLEEP:  nxt_state = ST_SLEEP;
						MODE_DSLEEP: nxt_state = ST_DSLEEP;
						MODE_PDOWN:  nxt_state = ST_PDOWN;
						MODE_DPD:    nxt_state = ST_DPD;
					endcase
				end
			end
			ST_SLEEP: begin
				if (sleep_wake)
					nxt_state = ST_RUN;
			end
			ST_DSLEEP: begin
				wt_val  = was_main_ff ? T_MAIN : T_FAST;
				wt_load = deep_wake;
				if (deep_wake)
					nxt_state = ST_RESUME;
			end
			ST_PDOWN: begin
				wt_val  = T_IRCUP;
				wt_load = deep_wake;
				ft_load = deep_wake;
				if (deep_wake)
					nxt_state = ST_OSC_UP;
			end
			ST_OSC_UP: begin
				wt_val  = T_FAST;
				wt_load = wt_done;
				if (wt_done)
					nxt_state = ST_RESUME;
			end
			ST_RESUME: begin
				if (wt_done && !wt_load)
					nxt_state = ST_RUN;
			end
			ST_DPD: begin
				if (alarm_s)
					nxt_state = ST_RST_HOLD;
			end
			default: nxt_state = ST_RST_HOLD;
		endcase
	end

	always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			state_ff     <= ST_RST_HOLD;
			reset_arm_ff <= 1'b1;
		end else begin
			state_ff     <= nxt_state;
			reset_arm_ff <= (nxt_state == ST_RST_HOLD) && (state_ff != ST_RST_HOLD);
		end
	end

	// ****************************************
	// Software state and automatic clears
	// ****************************************
	always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			mode_ff     <= MODE_SLEEP;
			rtc_keep_ff <= 1'b1;
			pclk_ff     <= NPER'(PCLK_RST);
			div_ff      <= DIVW'(DIV_RST);
			clkcfg_ff   <= CLKCFG_RST;
			exit_ff     <= '0;
			wmask_ff    <= '0;
			was_main_ff <= 1'b0;
			from_pd_ff  <= 1'b0;
		end else begin
			if (wr_ctrl) begin
				mode_ff     <= pmw_mode_e'(PWDATA_IN[CTRL_MODE_LSB +: 2]);
				rtc_keep_ff <= PWDATA_IN[CTRL_RTCKEEP];
			end
			if (wr_pclk)
				pclk_ff <= PWDATA_IN[NPER-1:0];
			// Entry clears outrank a same-cycle write
			if (entering_deep)
				div_ff <= DIVW'(DIV_RST);
			else if (wr_div)
				div_ff <= PWDATA_IN[DIVW-1:0];
			if (entering_deep) begin
				clkcfg_ff.pll0_en  <= 1'b0;
				clkcfg_ff.pll_conn <= 1'b0;
				clkcfg_ff.pll1_en  <= entering_pd ? 1'b0 : clkcfg_ff.pll1_en;
				if (entering_pd) begin
					clkcfg_ff.main_osc_en <= 1'b0;
					clkcfg_ff.use_main    <= 1'b0;
					clkcfg_ff.clk_sel     <= CLKSEL_RST;
				end
			end else if (wr_cfg)
				clkcfg_ff <= pmw_clkcfg_s'(PWDATA_IN[6:0]);
			if (state_ff == ST_RST_HOLD)
				clkcfg_ff.use_main <= 1'b0;
			// Set wins over a same-cycle clear
			exit_ff <= (exit_ff & ~(wr_stat ? PWDATA_IN[STAT_EXIT_LSB +: 4] : 4'h0))
			           | exit_evt;
			if (entering_deep) begin
				wmask_ff    <= WAKE_MASK_IN;
				was_main_ff <= clkcfg_ff.use_main;
			end
			if (leave_deep)
				from_pd_ff <= (state_ff == ST_PDOWN);
		end
	end

	// ****************************************
	// Flash availability
	// ****************************************
	always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN)
			flash_ok_ff <= 1'b0;
		else if (state_ff == ST_PDOWN || state_ff == ST_DPD || state_ff == ST_RST_HOLD)
			flash_ok_ff <= 1'b0;
		else if (state_ff == ST_RUN && from_pd_ff)
			flash_ok_ff <= ft_done;
		else if (state_ff == ST_RUN)
			flash_ok_ff <= 1'b1;
	end

	// ****************************************
	// Power and clock outputs
	// ****************************************
	wire st_dsl = (state_ff == ST_DSLEEP);
	wire st_pd  = (state_ff == ST_PDOWN);
	wire st_dpd = (state_ff == ST_DPD);
	wire st_slp = (state_ff == ST_SLEEP);
	wire deep   = st_dsl || st_pd || st_dpd;

	always_ff @(posedge CLOCK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			CORE_CLK_EN_OUT   <= 1'b0;
			EXEC_EN_OUT       <= 1'b0;
			FLASH_ACCESS_OUT  <= 1'b0;
			FLASH_PWR_OUT     <= 1'b1;
			SRAM_EN_OUT       <= 1'b1;
			DMA_EN_OUT        <= 1'b1;
			PERIPH_CLK_ON_OUT <= 1'b1;
			IRC_PWR_OUT       <= 1'b1;
			IRC_OUT_EN_OUT    <= 1'b1;
			PIN_HOLD_OUT      <= 1'b0;
			CORE_PWR_OUT      <= 1'b1;
			RTC_OSC_PWR_OUT   <= 1'b1;
			WDT_CLK_EN_OUT    <= 1'b0;
			CLKCFG_OUT        <= CLKCFG_RST;
			CLK_DIV_OUT       <= '0;
			PCLK_EN_OUT       <= '0;
		end else begin
			CORE_CLK_EN_OUT   <= exec_on;
			EXEC_EN_OUT       <= exec_on;
			FLASH_ACCESS_OUT  <= flash_ok_ff && exec_on;
			FLASH_PWR_OUT     <= !(st_pd || st_dpd);
			SRAM_EN_OUT       <= !st_slp;
			DMA_EN_OUT        <= !deep;
			PERIPH_CLK_ON_OUT <= !deep;
			IRC_PWR_OUT       <= !(st_pd || st_dpd);
			IRC_OUT_EN_OUT    <= !deep && state_ff != ST_OSC_UP;
			PIN_HOLD_OUT      <= deep;
			CORE_PWR_OUT      <= !st_dpd;
			RTC_OSC_PWR_OUT   <= !st_dpd || rtc_keep_ff;
			WDT_CLK_EN_OUT    <= WDT_RUN_IN;
			CLKCFG_OUT        <= deep ? CLKCFG_RST : clkcfg_ff;
			CLK_DIV_OUT       <= div_ff;
			PCLK_EN_OUT       <= deep ? '0 : pclk_ff;
		end
	end

	assign PRDATA_OUT  = rdata_ff;
	assign PREADY_OUT  = ready_ff;
	assign PSLVERR_OUT = slverr_ff;

endmodule : pmw_sequencer

//--- pmw_properties.sv
`timescale 1ns/10ps
module pmw_properties
	import pmw_pkg::*;
(
	input wire logic        CLOCK_IN,
	input wire logic        RSTN_IN,
	input wire logic        SLEEP_REQ_IN,
	input wire logic        WDT_RUN_IN,
	input wire logic        PREADY_OUT,
	input wire logic        PSLVERR_OUT,
	input wire logic        CORE_CLK_EN_OUT,
	input wire logic        EXEC_EN_OUT,
	input wire logic        FLASH_ACCESS_OUT,
	input wire logic        FLASH_PWR_OUT,
	input wire logic        SRAM_EN_OUT,
	input wire logic        DMA_EN_OUT,
	input wire logic        PERIPH_CLK_ON_OUT,
	input wire logic        IRC_PWR_OUT,
	input wire logic        IRC_OUT_EN_OUT,
	input wire logic        PIN_HOLD_OUT,
	input wire logic        CORE_PWR_OUT,
	input wire logic        RTC_OSC_PWR_OUT,
	input wire logic        WDT_CLK_EN_OUT,
	input wire pmw_clkcfg_s CLKCFG_OUT
);
	// ********
	// Checks
	// ********
	default clocking cb @(posedge CLOCK_IN); endclocking
	default disable iff (!RSTN_IN);

	chk_core_exec_pair: assert property (EXEC_EN_OUT == CORE_CLK_EN_OUT)
		else $error("core clock and execution enable differ");
	chk_sleep_entry: assert property (SLEEP_REQ_IN && EXEC_EN_OUT |-> ##2 !EXEC_EN_OUT)
		else $error("sleep request not taken in two cycles");
	chk_deep_gating: assert property (PIN_HOLD_OUT |->
		!DMA_EN_OUT && !PERIPH_CLK_ON_OUT && !IRC_OUT_EN_OUT)
		else $error("clocks running in a deep mode");
	chk_deep_flash_on: assert property (PIN_HOLD_OUT && IRC_PWR_OUT |-> FLASH_PWR_OUT)
		else $error("flash unpowered in deep sleep");
	chk_pdown_state: assert property (!IRC_PWR_OUT |->
		!FLASH_PWR_OUT && PIN_HOLD_OUT && CLKCFG_OUT == CLKCFG_RST)
		else $error("power down state incomplete");
	chk_sleep_dma: assert property (!SRAM_EN_OUT && !PIN_HOLD_OUT |-> DMA_EN_OUT && PERIPH_CLK_ON_OUT)
		else $error("dma or peripherals stopped in sleep");
	chk_flash_gate: assert property (FLASH_ACCESS_OUT |-> FLASH_PWR_OUT)
		else $error("flash access without flash power");
	chk_wdt_follow: assert property ($past(RSTN_IN) |-> WDT_CLK_EN_OUT == $past(WDT_RUN_IN))
		else $error("watchdog clock does not follow run");
	chk_rtc_keep: assert property (!RTC_OSC_PWR_OUT |-> !CORE_PWR_OUT && !IRC_PWR_OUT)
		else $error("rtc oscillator off outside deep power down");
	chk_apb_answer: assert property (PSLVERR_OUT |-> PREADY_OUT ##1 !PREADY_OUT)
		else $error("error response outside one access cycle");

	cov_sleep: cover property (!SRAM_EN_OUT && !PIN_HOLD_OUT);
	cov_deep: cover property (PIN_HOLD_OUT && IRC_PWR_OUT);
	cov_pdown: cover property (!IRC_PWR_OUT && CORE_PWR_OUT);
	cov_dpd: cover property (!CORE_PWR_OUT);
endmodule : pmw_properties

bind pmw_sequencer pmw_properties u_chk (.CLOCK_IN, .RSTN_IN, .SLEEP_REQ_IN, .WDT_RUN_IN,
	.PREADY_OUT, .PSLVERR_OUT, .CORE_CLK_EN_OUT, .EXEC_EN_OUT, .FLASH_ACCESS_OUT,
	.FLASH_PWR_OUT, .SRAM_EN_OUT, .DMA_EN_OUT, .PERIPH_CLK_ON_OUT, .IRC_PWR_OUT,
	.IRC_OUT_EN_OUT, .PIN_HOLD_OUT, .CORE_PWR_OUT, .RTC_OSC_PWR_OUT, .WDT_CLK_EN_OUT,
	.CLKCFG_OUT);

//--- pmw_core_model.sv
`timescale 1ns/10ps
module pmw_core_model #(
	parameter int NIRQ = 16
) (
	input  wire logic            clk_in,
	input  wire logic            rstn_in,
	input  wire logic            exec_en_in,
	input  wire logic            sleep_go_in,
	input  wire logic [NIRQ-1:0] irq_set_in,
	input  wire logic [NIRQ-1:0] mask_in,
	output logic                 sleep_req_out,
	output logic [NIRQ-1:0]      irq_out,
	output logic [NIRQ-1:0]      wake_mask_out
);
	// ********
	// Core side
	// ********
	logic exec_d_ff;
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			sleep_req_out <= 1'b0;
			irq_out       <= '0;
			wake_mask_out <= '0;
			exec_d_ff     <= 1'b0;
		end else begin
			exec_d_ff     <= exec_en_in;
			wake_mask_out <= mask_in;
			// Dropped once taken, else a wake would re-enter at once
			if (sleep_go_in) begin
				sleep_req_out <= 1'b1;
			end else if (!exec_en_in) begin
				sleep_req_out <= 1'b0;
			end
			// Pending lines stay until the core resumes and services them
			if (exec_en_in && !exec_d_ff) begin
				irq_out <= '0;
			end else begin
				irq_out <= irq_out | irq_set_in;
			end
		end
	end
endmodule : pmw_core_model

//--- tb.sv
`timescale 1ns/10ps
module tb;
	import pmw_pkg::*;
	logic        clk, rstn, psel, pen, pwr, go, alarm, osc, fid, wdt;
	logic        pready, pslverr, req, cclk, exec, facc, fpwr, sram, dma, pon;
	logic        ircp, irco, hold, cpwr, rtcp, wdtc;
	logic [7:0]  paddr, div;
	logic [31:0] pwdata, prdata, pclk, pcen;
	logic [15:0] irq, wmask, iset, mval, m;
	pmw_clkcfg_s cfg;
	int          fails, cmp_count, n, n2, e;
	logic [32:0] expq[$];
	logic [7:0]  ofs[5];
	logic [32:0] rv[5];

	pmw_sequencer dut (
		.CLOCK_IN(clk), .RSTN_IN(rstn), .PSEL_IN(psel), .PENABLE_IN(pen),
		.PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
		.PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .SLEEP_REQ_IN(req), .IRQ_IN(irq),
		.WAKE_MASK_IN(wmask), .RTC_ALARM_IN(alarm), .OSC_OK_IN(osc),
		.FLASH_INIT_DONE_IN(fid), .WDT_RUN_IN(wdt), .CORE_CLK_EN_OUT(cclk),
		.EXEC_EN_OUT(exec), .FLASH_ACCESS_OUT(facc), .FLASH_PWR_OUT(fpwr),
		.SRAM_EN_OUT(sram), .DMA_EN_OUT(dma), .PERIPH_CLK_ON_OUT(pon),
		.IRC_PWR_OUT(ircp), .IRC_OUT_EN_OUT(irco), .PIN_HOLD_OUT(hold),
		.CORE_PWR_OUT(cpwr), .RTC_OSC_PWR_OUT(rtcp), .WDT_CLK_EN_OUT(wdtc),
		.CLKCFG_OUT(cfg), .CLK_DIV_OUT(div), .PCLK_EN_OUT(pcen));
	pmw_core_model u_core (.clk_in(clk), .rstn_in(rstn), .exec_en_in(exec), .sleep_go_in(go),
		.irq_set_in(iset), .mask_in(mval), .sleep_req_out(req), .irq_out(irq),
		.wake_mask_out(wmask));

	// ********
	// Tasks
	// ********
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic end_sim;
		if (fails == 0 && cmp_count > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : end_sim

	// No wait bound: a stuck slave is cut short by the watchdog
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [32:0] x);
		expq.push_back(x);
		@(posedge clk);
		psel   <= 1'b1;
		pwr    <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge clk) pen <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		psel <= 1'b0;
		pen  <= 1'b0;
	endtask : apb

	task automatic wait_hi(input bit f, input int lim, output int c);
		c = 0;
		while ((f ? facc : exec) !== 1'b1 && c < lim) begin
			@(negedge clk);
			c++;
		end
	endtask : wait_hi

	task automatic enter(input logic [31:0] ctrl);
		apb(1'b1, OFS_CTRL, ctrl, 33'h0_0000_0000);
		@(posedge clk) go <= 1'b1;
		@(posedge clk) go <= 1'b0;
		repeat (8) @(negedge clk);
	endtask : enter

	task automatic wake(input logic [15:0] b, input int lim, output int c);
		@(posedge clk) iset <= b;
		@(posedge clk) iset <= '0;
		wait_hi(1'b0, lim, c);
	endtask : wake

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	always @(posedge clk) if (pready === 1'b1) chk({pslverr, prdata}, expq.pop_front());

	initial begin
		#490000;
		fails++;
		end_sim();
	end

	// ********
	// Scenarios
	// ********
	initial begin
		{rstn, psel, pen, pwr, go, alarm, osc, fid, wdt} = '0;
		paddr  = '0;
		pwdata = '0;
		iset   = '0;
		mval   = '0;
		ofs = '{OFS_CTRL, OFS_PCLK, OFS_DIV, OFS_CLKCFG, 8'h14};
		rv = '{33'h0_0000_0004, {1'b0, PCLK_RST}, 33'h0_0000_0000, 33'h0_0000_0000,
			33'h1_0000_0000};
		void'($urandom(98));
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		repeat (1500) @(negedge clk);
		chk(exec, 1'b0);
		@(posedge clk) begin
			osc <= 1'b1;
			fid <= 1'b1;
			wdt <= 1'b1;
		end
		wait_hi(1'b0, 1200, n);
		chk(n < 1200, 1);
		chk(cfg, CLKCFG_RST);
		foreach (ofs[i]) apb(1'b0, ofs[i], 32'h0000_0000, rv[i]);
		apb(1'b1, 8'h14, 32'hFFFF_FFFF, 33'h1_0000_0000);
		pclk = $urandom;
		apb(1'b1, OFS_PCLK, pclk, 33'h0_0000_0000);
		// Enable output follows the register one cycle later
		repeat (2) @(negedge clk);
		chk(pcen, pclk);
		m = (16'($urandom) & 16'hFFFE) | 16'h0002;
		@(posedge clk) mval <= m;
		enter(32'h0000_0004);
		chk({exec, sram, dma, fpwr}, 4'b0011);
		wake(16'h0001, 40, n);
		chk(exec, 1'b0);
		wake(16'h0002, 40, n);
		chk(n <= 8, 1);
		apb(1'b0, OFS_STATUS, 32'h0000_0000, 33'h0_0000_0131);
		apb(1'b1, OFS_STATUS, 32'h0000_0001, 33'h0_0000_0000);
		for (int u = 1; u >= 0; u--) begin
			apb(1'b1, OFS_DIV, 32'h0000_00A5, 33'h0_0000_0000);
			apb(1'b1, OFS_CLKCFG, 32'h0000_0078 | (u << 2), 33'h0_0000_0000);
			enter(32'h0000_0005);
			// Mask cleared after entry; only the latched copy may wake
			@(posedge clk) mval <= '0;
			chk({hold, fpwr, ircp, div, cfg.pll0_en, cfg.pll_conn}, {3'b111, 10'h000});
			wake(16'h0002, 70000, n);
			e = (u ? MAIN_WAKE_CYC : FAST_WAKE_CYC) * CLK_KHZ / IRC_KHZ;
			chk(n > e - 20 && n < e + 30, 1);
			// Main PLL off and cut loose; other fields survive Deep-sleep
			apb(1'b0, OFS_CLKCFG, 32'h0000_0000, 33'(32'h0000_0028 | (u << 2)));
			@(posedge clk) mval <= m;
			apb(1'b1, OFS_DIV, 32'h0000_0003, 33'h0_0000_0000);
		end
		enter(32'h0000_0006);
		chk({ircp, fpwr, cfg, div}, {2'b00, CLKCFG_RST, 8'h00});
		wake(16'h0002, 20000, n);
		e = (IRC_STARTUP_CYC + FAST_WAKE_CYC) * CLK_KHZ / IRC_KHZ;
		chk(n > e - 20 && n < e + 30, 1);
		chk(facc, 1'b0);
		wait_hi(1'b1, 10000, n2);
		e = FLASH_WAKE_CYC * CLK_KHZ / IRC_KHZ;
		chk(n + n2 > e - 20 && n + n2 < e + 30, 1);
		apb(1'b0, OFS_CLKCFG, 32'h0000_0000, 33'h0_0000_0000);
		apb(1'b0, OFS_STATUS, 32'h0000_0000, 33'h0_0000_0136);
		apb(1'b1, OFS_STATUS, 32'h0000_0006, 33'h0_0000_0000);
		enter(32'h0000_0003);
		chk({cpwr, rtcp, ircp}, 3'b000);
		wake(16'h0002, 100, n);
		chk(cpwr, 1'b0);
		@(posedge clk) alarm <= 1'b1;
		wait_hi(1'b0, 1500, n);
		@(posedge clk) alarm <= 1'b0;
		chk(n < 1500, 1);
		apb(1'b0, OFS_STATUS, 32'h0000_0000, 33'h0_0000_0138);
		end_sim();
	end
endmodule : tb
